// ---- design/dram_init_pkg.sv ----
// Constants, tables and carrier types shared by the DRAM init sequencer and its address mapper.
// Assumes a single 125 MHz controller clock and a simple word-wide register port.
package dram_init_pkg;
    // Register offsets
    localparam logic [7:0] INIT_CMD_OFFSET = 8'h7c;
    localparam logic [7:0] ADDR_MODE_OFFSET = 8'h80;
    localparam logic [31:0] INIT_CMD_RESET = 32'h0;
    localparam logic [31:0] ADDR_MODE_RESET = 32'h0;

    // Field positions of the init command register
    localparam int INIT_EN_BIT = 31;
    localparam int CKE_RAISE_BIT = 28;
    localparam int RST_RELEASE_BIT = 27;
    localparam int MRS_GO_BIT = 26;
    localparam int REFRESH_GO_BIT = 25;
    localparam int PCHG_GO_BIT = 24;
    localparam int MRS_BANK_LSB = 16;
    localparam int MRS_ADDR_LSB = 0;
    // Address-mode fields: four nibbles, one per chip-select pair
    localparam int PAIR_FIELD_W = 4;
    localparam int ADDR_MODE_W = 16;

    // Command recovery time before a go bit is cleared
    localparam int CLK_PERIOD_PS = 8000;
    localparam int CMD_WAIT_NS = 64;
    localparam int CMD_WAIT_CYCLES = (CMD_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Address map, 64-bit interface; a 128-bit interface shifts every source up by one
    localparam int PA_W = 40;
    localparam logic [3:0] LAST_MODE = 4'hb;
    localparam int ROW_FIXED_LSB = 18;
    localparam int ROW_HI_BASE = 27;
    localparam int ROW_LO_TOP = 17;
    localparam int COL_LSB = 3;
    localparam int COL11_SRC = 13;
    localparam int AP_LINE = 10;
    localparam logic [2:0] ROW_HI_CNT [0:11] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h2, 3'h3,
                                                 3'h3, 3'h4, 3'h4, 3'h5, 3'h5, 3'h6};
    localparam logic [2:0] ROW_LO_CNT [0:11] = '{3'h4, 3'h3, 3'h3, 3'h2, 3'h2, 3'h2,
                                                 3'h2, 3'h2, 3'h1, 3'h1, 3'h2, 3'h1};
    localparam logic [4:0] BANK_LSB [0:11] = '{5'h0c, 5'h0d, 5'h0d, 5'h0e, 5'h0d, 5'h0d,
                                               5'h0e, 5'h0d, 5'h0e, 5'h0e, 5'h0d, 5'h0e};
    localparam logic [11:0] BANK_THREE = 12'hfb0;
    localparam logic [11:0] COL9_EN = 12'hffe;
    localparam logic [11:0] X4_MODE = 12'hb48;

    typedef enum logic [2:0] {
        CMD_NOP,
        CMD_PRECHARGE_ALL,
        CMD_REFRESH,
        CMD_MODE_REG,
        CMD_ACTIVATE,
        CMD_COLUMN
    } dram_cmd_e;

    typedef enum logic [0:0] {
        PH_IDLE,
        PH_WAIT
    } phase_e;

    typedef struct packed {
        dram_cmd_e cmd;
        logic [15:0] addr;
        logic [2:0] bank;
    } dram_bus_s;

    typedef struct packed {
        logic [15:0] row;
        logic [15:0] col;
        logic [2:0] bank;
    } map_s;
endpackage

// ---- design/dram_addr_map.sv ----
// Address-mode decoder: physical address to DRAM row, column and bank lines.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module dram_addr_map (
    input wire logic [3:0] mode,
    input wire logic wide,
    input wire logic [dram_init_pkg::PA_W-1:0] pa,
    output dram_init_pkg::map_s map
);
    // One table drives both widths, only the source offset moves
    function automatic dram_init_pkg::map_s map_addr(input logic [3:0] m,
                                                     input logic w,
                                                     input logic [dram_init_pkg::PA_W-1:0] a);
        dram_init_pkg::map_s r;
        int s;
        int hi;
        int lo;
        r = '0;
        s = w ? 1 : 0;
        hi = 0;
        lo = 0;
        // Reserved encodings map to zeros so nothing stray reaches the pins
        if (m <= dram_init_pkg::LAST_MODE) begin
            hi = int'(dram_init_pkg::ROW_HI_CNT[m]);
            lo = int'(dram_init_pkg::ROW_LO_CNT[m]);
            for (int i = 0; i < 9; i++) begin
                r.row[i] = a[dram_init_pkg::ROW_FIXED_LSB + i + s];
                r.col[i] = a[dram_init_pkg::COL_LSB + i + s];
            end
            for (int i = 0; i < 7; i++) begin
                if (i < hi) begin
                    r.row[9 + i] = a[dram_init_pkg::ROW_HI_BASE + i + s];
                end else if (i < hi + lo) begin
                    r.row[9 + i] = a[dram_init_pkg::ROW_LO_TOP + 1 - lo + (i - hi) + s];
                end
            end
            if (dram_init_pkg::COL9_EN[m]) begin
                r.col[9] = a[dram_init_pkg::COL_LSB + 9 + s];
            end
            if (dram_init_pkg::X4_MODE[m]) begin
                r.col[11] = a[dram_init_pkg::COL11_SRC + s];
            end
            for (int i = 0; i < 3; i++) begin
                if (i < 2 || dram_init_pkg::BANK_THREE[m]) begin
                    r.bank[i] = a[int'(dram_init_pkg::BANK_LSB[m]) + i + s];
                end
            end
        end
        return r;
    endfunction

    // Decode
    assign map = map_addr(mode, wide, pa);
endmodule

// ---- design/dram_init_seq.sv ----
// DRAM init sequencer with its two registers and the chip-select address-mode mapping.
// Assumes register strobes and access requests come from logic on CLK.
//
// Notes on behaviour
// - Init-enable bit 31 selects firmware-driven init; commands only on register requests.
// - Setting init-enable asserts memory reset for registered DIMMs and drops CKE.
// - Bit 24 issues precharge-all; hardware clears it after completion.
// - Bit 25 issues auto-refresh; hardware clears it after completion.
// - Bit 26 issues a mode-register command from stored fields; cleared on completion.
// - Mode-register command drives the 16-bit mode address onto address lines 15-0.
// - Mode-register command drives the 3-bit mode bank onto the bank lines.
// - Bit 27 releases memory reset; writing zero never re-asserts it.
// - Bit 28 raises CKE; writing zero never lowers it.
// - Four 4-bit address-mode fields, one per chip-select pair, cover whole DIMMs.
// - Encodings mean the same module type on 64-bit and 128-bit interfaces.
// - On column commands address line 10 carries the auto-precharge flag.
// - Mode 0 on 64-bit maps bank 13:12, column 11:3, row 26:18 and 17:14.
// - Modes 0 to 11 span 128 MB to 8 GB; x4 adds bit 13 on column 11.
// - On a 128-bit interface every source address bit sits one position higher.
`timescale 1ns/1ps
module dram_init_seq #(
    parameter int WAIT_CYCLES = dram_init_pkg::CMD_WAIT_CYCLES
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    output logic [31:0] REG_RDATA,
    input wire logic REGISTERED_DIMM,
    input wire logic WIDE_IF,
    input wire logic ACC_VALID,
    output logic ACC_READY,
    input wire logic [2:0] ACC_CS,
    input wire logic ACC_COL,
    input wire logic ACC_AP,
    input wire logic [dram_init_pkg::PA_W-1:0] ACC_PA,
    output logic MEM_RESET_N,
    output logic CKE,
    output dram_init_pkg::dram_cmd_e DRAM_CMD,
    output logic [15:0] DRAM_ADDR,
    output logic [2:0] DRAM_BANK
);
    typedef struct packed {
        logic init_mode;
        logic cke_on;
        logic rst_released;
        logic mrs_go;
        logic refresh_go;
        logic pchg_go;
        logic [2:0] mrs_bank;
        logic [15:0] mrs_addr;
        logic [15:0] addr_mode;
        dram_init_pkg::phase_e phase;
        dram_init_pkg::dram_cmd_e active;
        logic [15:0] wait_cnt;
        dram_init_pkg::dram_bus_s bus;
        logic [31:0] rdata;
    } state_s;

    localparam logic [15:0] WAIT_LAST = 16'(WAIT_CYCLES - 1);

    state_s st;
    state_s next_st;
    dram_init_pkg::map_s map;
    logic [3:0] pair_mode;
    logic wr_init;
    logic wr_map;

    // Each chip-select pair shares one nibble, so both ranks of a DIMM decode alike
    assign pair_mode = st.addr_mode[ACC_CS[2:1] * dram_init_pkg::PAIR_FIELD_W +: 4];
    assign wr_init = REG_WR && (REG_ADDR == dram_init_pkg::INIT_CMD_OFFSET);
    assign wr_map = REG_WR && (REG_ADDR == dram_init_pkg::ADDR_MODE_OFFSET);

    dram_addr_map u_map (
        .mode(pair_mode),
        .wide(WIDE_IF),
        .pa(ACC_PA),
        .map(map)
    );

    // Normal traffic waits while firmware owns the command bus
    assign ACC_READY = !st.init_mode && (st.phase == dram_init_pkg::PH_IDLE);

    // Next-state logic: sequencer first, register writes last so a new set beats a clear
    always_comb begin
        next_st = st;
        next_st.bus.cmd = dram_init_pkg::CMD_NOP;
        next_st.bus.addr = 16'h0;
        next_st.bus.bank = 3'h0;
        next_st.rdata = 32'h0;
        case (st.phase)
            dram_init_pkg::PH_IDLE: begin
                if (st.init_mode) begin
                    // Fixed priority when firmware sets several go bits at once
                    if (st.pchg_go) begin
                        next_st.bus.cmd = dram_init_pkg::CMD_PRECHARGE_ALL;
                        next_st.bus.addr[dram_init_pkg::AP_LINE] = 1'b1;
                    end else if (st.refresh_go) begin
                        next_st.bus.cmd = dram_init_pkg::CMD_REFRESH;
                    end else if (st.mrs_go) begin
                        next_st.bus.cmd = dram_init_pkg::CMD_MODE_REG;
                        next_st.bus.addr = st.mrs_addr;
                        next_st.bus.bank = st.mrs_bank;
                    end
                    if (st.pchg_go || st.refresh_go || st.mrs_go) begin
                        next_st.active = next_st.bus.cmd;
                        next_st.phase = dram_init_pkg::PH_WAIT;
                        next_st.wait_cnt = WAIT_LAST;
                    end
                end else if (ACC_VALID) begin
                    next_st.bus.bank = map.bank;
                    if (ACC_COL) begin
                        next_st.bus.cmd = dram_init_pkg::CMD_COLUMN;
                        next_st.bus.addr = map.col;
                        next_st.bus.addr[dram_init_pkg::AP_LINE] = ACC_AP;
                    end else begin
                        next_st.bus.cmd = dram_init_pkg::CMD_ACTIVATE;
                        next_st.bus.addr = map.row;
                    end
                end
            end
            dram_init_pkg::PH_WAIT: begin
                if (st.wait_cnt == 16'h0) begin
                    // Completion: drop only the bit of the command that ran
                    case (st.active)
                        dram_init_pkg::CMD_PRECHARGE_ALL: next_st.pchg_go = 1'b0;
                        dram_init_pkg::CMD_REFRESH: next_st.refresh_go = 1'b0;
                        dram_init_pkg::CMD_MODE_REG: next_st.mrs_go = 1'b0;
                        default: next_st.pchg_go = st.pchg_go;
                    endcase
                    next_st.active = dram_init_pkg::CMD_NOP;
                    next_st.phase = dram_init_pkg::PH_IDLE;
                end else begin
                    next_st.wait_cnt = st.wait_cnt - 16'h1;
                end
            end
            default: next_st.phase = dram_init_pkg::PH_IDLE;
        endcase

        // Init command register write
        if (wr_init) begin
            next_st.init_mode = REG_WDATA[dram_init_pkg::INIT_EN_BIT];
            if (REG_WDATA[dram_init_pkg::INIT_EN_BIT] && !st.init_mode) begin
                next_st.rst_released = 1'b0;
                next_st.cke_on = 1'b0;
            end
            // Zero writes leave these alone, only init entry or reset can undo them
            if (REG_WDATA[dram_init_pkg::RST_RELEASE_BIT]) begin
                next_st.rst_released = 1'b1;
            end
            if (REG_WDATA[dram_init_pkg::CKE_RAISE_BIT]) begin
                next_st.cke_on = 1'b1;
            end
            if (REG_WDATA[dram_init_pkg::PCHG_GO_BIT]) begin
                next_st.pchg_go = 1'b1;
            end
            if (REG_WDATA[dram_init_pkg::REFRESH_GO_BIT]) begin
                next_st.refresh_go = 1'b1;
            end
            if (REG_WDATA[dram_init_pkg::MRS_GO_BIT]) begin
                next_st.mrs_go = 1'b1;
            end
            next_st.mrs_bank = REG_WDATA[dram_init_pkg::MRS_BANK_LSB +: 3];
            next_st.mrs_addr = REG_WDATA[dram_init_pkg::MRS_ADDR_LSB +: 16];
        end
        if (wr_map) begin
            next_st.addr_mode = REG_WDATA[dram_init_pkg::ADDR_MODE_W-1:0];
        end

        // Read data, one cycle after the strobe; reserved bits and unmapped offsets read zero
        if (REG_RD && (REG_ADDR == dram_init_pkg::INIT_CMD_OFFSET)) begin
            next_st.rdata[dram_init_pkg::INIT_EN_BIT] = st.init_mode;
            next_st.rdata[dram_init_pkg::CKE_RAISE_BIT] = st.cke_on;
            next_st.rdata[dram_init_pkg::RST_RELEASE_BIT] = st.rst_released;
            next_st.rdata[dram_init_pkg::MRS_GO_BIT] = st.mrs_go;
            next_st.rdata[dram_init_pkg::REFRESH_GO_BIT] = st.refresh_go;
            next_st.rdata[dram_init_pkg::PCHG_GO_BIT] = st.pchg_go;
            next_st.rdata[dram_init_pkg::MRS_BANK_LSB +: 3] = st.mrs_bank;
            next_st.rdata[dram_init_pkg::MRS_ADDR_LSB +: 16] = st.mrs_addr;
        end else if (REG_RD && (REG_ADDR == dram_init_pkg::ADDR_MODE_OFFSET)) begin
            next_st.rdata[dram_init_pkg::ADDR_MODE_W-1:0] = st.addr_mode;
        end
    end

    // State register; every field clears to zero
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Unbuffered DIMMs have no reset pin to hold, so reset follows only registered ones
    assign MEM_RESET_N = st.rst_released || !REGISTERED_DIMM;
    assign CKE = st.cke_on;
    assign DRAM_CMD = st.bus.cmd;
    assign DRAM_ADDR = st.bus.addr;
    assign DRAM_BANK = st.bus.bank;
    assign REG_RDATA = st.rdata;
endmodule

// ---- bench/dram_init_seq_asserts.sv ----
// Checker for the DRAM init sequencer: pin levels, command pulses and the access path.
// Sees only the top ports; the bind hands on WAIT_CYCLES.
`timescale 1ns/1ps
module dram_init_seq_asserts #(
    parameter int WAIT_CYCLES = 8
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic REG_WR,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REGISTERED_DIMM,
    input wire logic ACC_VALID,
    input wire logic ACC_READY,
    input wire logic ACC_COL,
    input wire logic ACC_AP,
    input wire logic MEM_RESET_N,
    input wire logic CKE,
    input wire dram_init_pkg::dram_cmd_e DRAM_CMD,
    input wire logic [15:0] DRAM_ADDR,
    input wire logic [2:0] DRAM_BANK
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    logic init_wr;
    logic seq_cmd;
    logic acc_cmd;
    // Decoded helpers; ACC_READY high means init mode is off and nothing waits
    assign init_wr = REG_WR && REG_ADDR == 8'h7c && REG_WDATA[31];
    assign seq_cmd = DRAM_CMD inside {dram_init_pkg::CMD_PRECHARGE_ALL,
        dram_init_pkg::CMD_REFRESH, dram_init_pkg::CMD_MODE_REG};
    assign acc_cmd = DRAM_CMD inside {dram_init_pkg::CMD_ACTIVATE, dram_init_pkg::CMD_COLUMN};

    chk_cke_drop: assert property (init_wr && !REG_WDATA[28] && ACC_READY |=> !CKE)
        else $error("CKE not lowered on entry to init mode");
    chk_reset_drive: assert property (init_wr && !REG_WDATA[27] && ACC_READY && REGISTERED_DIMM
        |=> !MEM_RESET_N) else $error("memory reset not asserted on init entry");
    chk_cke_hold: assert property (CKE && !init_wr |=> CKE)
        else $error("CKE dropped without init entry");
    chk_reset_hold: assert property (MEM_RESET_N && !init_wr |=> $stable(MEM_RESET_N))
        else $error("memory reset asserted again without init entry");
    chk_cmd_spacing: assert property (seq_cmd |=> (DRAM_CMD == dram_init_pkg::CMD_NOP)[*4])
        else $error("init command not followed by its recovery gap");
    chk_pchg_line: assert property (DRAM_CMD == dram_init_pkg::CMD_PRECHARGE_ALL
        |-> DRAM_ADDR == 16'h0400) else $error("precharge all without line 10 set");
    // Refresh carries no address, so stale mode fields must not leak onto the pins
    chk_refresh_quiet: assert property (DRAM_CMD == dram_init_pkg::CMD_REFRESH
        |-> DRAM_ADDR == 16'h0000 && DRAM_BANK == 3'h0)
        else $error("refresh command with address or bank lines set");
    chk_col_ap: assert property (ACC_VALID && ACC_READY && ACC_COL |=>
        DRAM_CMD == dram_init_pkg::CMD_COLUMN && DRAM_ADDR[10] == $past(ACC_AP))
        else $error("column command without its auto-precharge flag");
    chk_acc_gate: assert property (acc_cmd |-> $past(ACC_VALID) && $past(ACC_READY))
        else $error("access command without an accepted request");
endmodule

bind dram_init_seq dram_init_seq_asserts #(.WAIT_CYCLES(WAIT_CYCLES)) i_dram_init_seq_asserts (
    .CLK(CLK), .RSTN(RSTN), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REGISTERED_DIMM(REGISTERED_DIMM), .ACC_VALID(ACC_VALID), .ACC_READY(ACC_READY),
    .ACC_COL(ACC_COL), .ACC_AP(ACC_AP), .MEM_RESET_N(MEM_RESET_N), .CKE(CKE),
    .DRAM_CMD(DRAM_CMD), .DRAM_ADDR(DRAM_ADDR), .DRAM_BANK(DRAM_BANK));

// ---- bench/dimm_model.sv ----
// Memory module listener on the command bus: records what a fitted module would accept.
// Assumes one command per controller clock and commands valid for that one cycle.
`timescale 1ns/1ps
module dimm_model (
    input wire logic clk,
    input wire logic mem_reset_n,
    input wire logic cke,
    input wire dram_init_pkg::dram_cmd_e cmd,
    input wire logic [15:0] addr,
    input wire logic [2:0] bank,
    output int n_cmds,
    output dram_init_pkg::dram_cmd_e last_cmd,
    output logic [15:0] last_addr,
    output logic [2:0] last_bank
);
    initial n_cmds = 0;
    // A module held in reset or with CKE low ignores the bus, so early commands are lost
    always @(posedge clk) begin
        if (mem_reset_n && cke && cmd != dram_init_pkg::CMD_NOP) begin
            n_cmds <= n_cmds + 1;
            last_cmd <= cmd;
            last_addr <= addr;
            last_bank <= bank;
        end
    end
endmodule

// ---- bench/dram_init_seq_tb.sv ----
// Self-checking bench for the DRAM init sequencer and its address mapper.
// Assumes firmware-style register access and a short command recovery count.
`timescale 1ns/1ps
module dram_init_seq_tb;
    logic CLK = 1'b0, RSTN = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, WIDE_IF = 1'b0;
    logic REGISTERED_DIMM = 1'b1, ACC_VALID = 1'b0, ACC_COL = 1'b0, ACC_AP = 1'b0;
    logic [7:0] REG_ADDR = 8'h00;
    logic [31:0] REG_WDATA = 32'h0, REG_RDATA, d;
    logic [2:0] ACC_CS = 3'h0, DRAM_BANK, last_bank;
    logic [39:0] ACC_PA = 40'h01_a7c6_5b39;
    logic ACC_READY, MEM_RESET_N, CKE;
    logic [15:0] DRAM_ADDR, last_addr;
    dram_init_pkg::dram_cmd_e DRAM_CMD, last_cmd;
    int n_cmds, failures = 0, n_compared = 0;

    dram_init_seq #(.WAIT_CYCLES(4)) i_dram_init_seq (.CLK(CLK), .RSTN(RSTN), .REG_WR(REG_WR),
        .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
        .REGISTERED_DIMM(REGISTERED_DIMM), .WIDE_IF(WIDE_IF), .ACC_VALID(ACC_VALID),
        .ACC_READY(ACC_READY), .ACC_CS(ACC_CS), .ACC_COL(ACC_COL), .ACC_AP(ACC_AP),
        .ACC_PA(ACC_PA), .MEM_RESET_N(MEM_RESET_N), .CKE(CKE), .DRAM_CMD(DRAM_CMD),
        .DRAM_ADDR(DRAM_ADDR), .DRAM_BANK(DRAM_BANK));
    dimm_model i_dimm_model (.clk(CLK), .mem_reset_n(MEM_RESET_N), .cke(CKE), .cmd(DRAM_CMD),
        .addr(DRAM_ADDR), .bank(DRAM_BANK), .n_cmds(n_cmds), .last_cmd(last_cmd),
        .last_addr(last_addr), .last_bank(last_bank));

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic print_verdict;
        if (failures == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Register port: strobes last one cycle, read data arrives one cycle later
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge CLK) #1;
        REG_WR = 1'b1;
        REG_ADDR = a;
        REG_WDATA = v;
        @(posedge CLK) #1;
        REG_WR = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge CLK) #1;
        REG_RD = 1'b1;
        REG_ADDR = a;
        @(posedge CLK) #1;
        REG_RD = 1'b0;
        v = REG_RDATA;
    endtask
    // Issues one go bit and leaves the register alone until hardware clears it
    task automatic send_cmd(input int b, input dram_init_pkg::dram_cmd_e exp);
        int n0;
        n0 = n_cmds;
        wr(8'h7c, 32'h9805_a5c3 | (32'h1 << b));
        for (int i = 0; i < 20 && n_cmds == n0; i++) @(posedge CLK);
        chk("command", last_cmd, exp);
        if (exp == dram_init_pkg::CMD_MODE_REG) begin
            chk("mode addr", last_addr, 32'h0000_a5c3);
            chk("mode bank", last_bank, 32'h5);
        end
        for (int i = 0; i < 10; i++) begin
            rd(8'h7c, d);
            if (d[b] === 1'b0) break;
        end
        chk("go cleared", d, 32'h9805_a5c3);
        chk("one command", n_cmds, n0 + 1);
    endtask
    // One normal access; masks keep only the lines the address mode defines
    task automatic map_chk(input logic [2:0] cs, input logic col, ap, wide,
        input logic [15:0] m, ea, input logic [2:0] bm, eb);
        @(posedge CLK) #1;
        WIDE_IF = wide;
        ACC_CS = cs;
        ACC_COL = col;
        ACC_AP = ap;
        ACC_VALID = 1'b1;
        @(posedge CLK) #1;
        ACC_VALID = 1'b0;
        chk("access cmd", DRAM_CMD, col ? dram_init_pkg::CMD_COLUMN : dram_init_pkg::CMD_ACTIVATE);
        chk("access addr", DRAM_ADDR & m, ea);
        chk("access bank", DRAM_BANK & bm, eb);
    endtask

    initial forever #4 CLK = ~CLK;
    // Watchdog well beyond the fewer than one hundred cycles the sequence needs
    initial begin
        #100000;
        failures++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge CLK);
        #1 RSTN = 1'b1;
        rd(8'h7c, d);
        chk("init reg reset", d, 32'h0);
        rd(8'h80, d);
        chk("mode reg reset", d, 32'h0);
        rd(8'h84, d);
        chk("unmapped read", d, 32'h0);
        wr(8'h7c, 32'h8000_0000);
        chk("reset on entry", MEM_RESET_N, 1'b0);
        chk("cke on entry", CKE, 1'b0);
        chk("ready in init", ACC_READY, 1'b0);
        wr(8'h7c, 32'h9800_0000);
        wr(8'h7c, 32'he0f8_0000);
        chk("reset released", MEM_RESET_N, 1'b1);
        chk("cke raised", CKE, 1'b1);
        rd(8'h7c, d);
        chk("init reg reserved", d, 32'h9800_0000);
        send_cmd(24, dram_init_pkg::CMD_PRECHARGE_ALL);
        send_cmd(25, dram_init_pkg::CMD_REFRESH);
        send_cmd(26, dram_init_pkg::CMD_MODE_REG);
        wr(8'h80, 32'hffff_b030);
        rd(8'h80, d);
        chk("mode fields", d, 32'h0000_b030);
        wr(8'h7c, 32'h0);
        chk("ready after init", ACC_READY, 1'b1);
        map_chk(3'h0, 0, 0, 0, 16'h1fff, {3'h0, ACC_PA[17:14], ACC_PA[26:18]}, 3'h3,
            {1'b0, ACC_PA[13:12]});
        map_chk(3'h1, 1, 1, 0, 16'h05ff, {6'h01, 1'b0, ACC_PA[11:3]}, 3'h3,
            {1'b0, ACC_PA[13:12]});
        map_chk(3'h2, 1, 0, 0, 16'h0fff, {4'h0, ACC_PA[13], 1'b0, ACC_PA[12:3]}, 3'h3,
            {1'b0, ACC_PA[15:14]});
        map_chk(3'h6, 0, 0, 0, 16'hffff, {ACC_PA[17], ACC_PA[32:18]}, 3'h7, ACC_PA[16:14]);
        map_chk(3'h0, 0, 0, 1, 16'h1fff, {3'h0, ACC_PA[18:15], ACC_PA[27:19]}, 3'h3,
            {1'b0, ACC_PA[14:13]});
        map_chk(3'h3, 1, 1, 1, 16'h0fff, {4'h0, ACC_PA[14], 1'b1, ACC_PA[13:4]}, 3'h3,
            {1'b0, ACC_PA[16:15]});
        print_verdict();
    end
endmodule
